// File: amws_defines.vh
// Constants for the asynchronous memory write strobe sequencer
// Contract
// - Every write interval counts whole system clock periods.
// - Setup, strobe, hold, turnaround and max wait are software set.
// - Extended wait off: strobe low exactly the programmed strobe count, one clock for a count of zero.
// - Extended wait on: strobe count plus sixteen per wait cycle.
// - Strobe rises four clocks after a wait step sees the synchronised wait input released.
// - Write data is driven for the setup count before the strobe falls.
// - Write data stays valid for the hold count after the strobe rises.
// - External wait cycle count reaches up to 256; counter sized for it.
// - Waiting stops once the programmed maximum wait cycles have passed.
// - Address is driven for the setup count before the strobe falls.
// - Address stays valid for the hold count after the strobe rises.
`ifndef AMWS_DEFINES_VH
`define AMWS_DEFINES_VH
// ==========================================================
// Register offsets (byte addresses)
`define AMWS_REG_CTRL 5'h00
`define AMWS_REG_TIME 5'h04
`define AMWS_REG_WAIT 5'h08
`define AMWS_REG_ADDR 5'h0c
`define AMWS_REG_DATA 5'h10
`define AMWS_REG_STAT 5'h14
// ==========================================================
// Field positions
`define AMWS_CTRL_WAIT_EN 0
`define AMWS_TIME_SETUP 3:0
`define AMWS_TIME_STROBE 13:8
`define AMWS_TIME_HOLD 19:16
`define AMWS_TIME_TURN 25:24
`define AMWS_WAIT_MAX 7:0
// ==========================================================
// Reset values
`define AMWS_TIME_RST 32'h0301_3f0f
`define AMWS_WAIT_RST 8'h80
// ==========================================================
// Timing
`define AMWS_WAIT_STEP 5'h10
`define AMWS_RELEASE_DLY 3'h4
`endif

// File: amws_wait_sync.v
// Two-stage synchroniser for the external wait input
`timescale 1ns/1ps
module amws_wait_sync (
  // Clock and reset
  input wire clk_sys,
  input wire reset,
  input wire clkEn,
  // Data
  input wire asyncIn,
  output reg syncOut
);
  reg stage1_r;

  // ==========================================================
  // Synchroniser flops
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      stage1_r <= 1'b0;
      syncOut <= 1'b0;
    end else if (clkEn) begin
      stage1_r <= asyncIn;
      syncOut <= stage1_r;
    end
  end
endmodule

// File: amws_wb_regs.v
// Wishbone classic register file for the write sequencer
`timescale 1ns/1ps
`include "amws_defines.vh"
module amws_wb_regs (
  // Clock and reset
  input wire clk_sys,
  input wire reset,
  input wire clkEn,
  // Wishbone slave
  input wire wbCyc,
  input wire wbStb,
  input wire wbWe,
  input wire [3:0] wbSel,
  input wire [4:0] wbAdr,
  input wire [31:0] wbDatIn,
  output reg [31:0] wbDatOut,
  output reg wbAck,
  // Control to sequencer
  output reg extendedWaitEnable,
  output reg [31:0] timeReg,
  output reg [7:0] maxWaitCycles,
  output reg [20:0] wrAddr,
  output reg [15:0] wrData,
  output reg startPulse,
  // Status from sequencer
  input wire busy,
  input wire timeoutSticky,
  input wire [8:0] lastWaitCount
);
  wire req = wbCyc & wbStb & ~wbAck;
  wire [31:0] ctrlRd = {31'h0, extendedWaitEnable};
  wire [31:0] statRd = {15'h0, lastWaitCount, 6'h0, timeoutSticky, busy};
  // Word offset of the access, byte bits forced to zero
  wire [4:0] regOff = {wbAdr[4:2], 2'h0};

  // ==========================================================
  // Byte-lane merge of write data into a register
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] sel;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (sel[i]) begin
          merge[i*8 +: 8] = nw[i*8 +: 8];
        end
      end
    end
  endfunction

  // Merged address and data words, cut to the register widths
  wire [31:0] addrMerged = merge({11'h0, wrAddr}, wbDatIn, wbSel);
  wire [31:0] dataMerged = merge({16'h0, wrData}, wbDatIn, wbSel);

  // ==========================================================
  // Register writes, read mux and single-cycle ack
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      wbAck <= 1'b0;
      wbDatOut <= 32'h0;
      extendedWaitEnable <= 1'b0;
      timeReg <= `AMWS_TIME_RST;
      maxWaitCycles <= `AMWS_WAIT_RST;
      wrAddr <= 21'h0;
      wrData <= 16'h0;
      startPulse <= 1'b0;
    end else if (clkEn) begin
      wbAck <= req;
      startPulse <= 1'b0;
      if (req && wbWe) begin
        case (regOff)
          `AMWS_REG_CTRL: begin
            if (wbSel[0]) extendedWaitEnable <= wbDatIn[`AMWS_CTRL_WAIT_EN];
          end
          `AMWS_REG_TIME: begin
            timeReg <= merge(timeReg, wbDatIn, wbSel);
          end
          `AMWS_REG_WAIT: begin
            if (wbSel[0]) maxWaitCycles <= wbDatIn[`AMWS_WAIT_MAX];
          end
          `AMWS_REG_ADDR: begin
            wrAddr <= addrMerged[20:0];
          end
          `AMWS_REG_DATA: begin
            wrData <= dataMerged[15:0];
            startPulse <= ~busy; // Write to data launches a cycle when idle
          end
          default: begin
            wbDatOut <= wbDatOut;
          end
        endcase
      end
      if (req && !wbWe) begin
        case (regOff)
          `AMWS_REG_CTRL: wbDatOut <= ctrlRd;
          `AMWS_REG_TIME: wbDatOut <= timeReg;
          `AMWS_REG_WAIT: wbDatOut <= {24'h0, maxWaitCycles};
          `AMWS_REG_ADDR: wbDatOut <= {11'h0, wrAddr};
          `AMWS_REG_DATA: wbDatOut <= {16'h0, wrData};
          `AMWS_REG_STAT: wbDatOut <= statRd;
          default: wbDatOut <= 32'h0;
        endcase
      end
    end
  end
endmodule

// File: amws_write_seq.v
// Top: write strobe sequencer for asynchronous external memory
`timescale 1ns/1ps
`include "amws_defines.vh"
module amws_write_seq #(
  parameter CNT_W = 9
) (
  // Clock, reset, enable
  input wire clk_sys,
  input wire reset,
  input wire clkEn,
  // Wishbone slave
  input wire wbCyc,
  input wire wbStb,
  input wire wbWe,
  input wire [3:0] wbSel,
  input wire [4:0] wbAdr,
  input wire [31:0] wbDatIn,
  output wire [31:0] wbDatOut,
  output wire wbAck,
  // External memory pins
  output reg ext_write_strobe_n,
  output reg [20:0] ext_address_bus,
  output reg [15:0] extDataOut,
  output reg extDataOe,
  input wire [15:0] extDataIn,
  input wire ext_wait_input
);
  // ==========================================================
  // States
  localparam ST_IDLE = 3'h0;
  localparam ST_SETUP = 3'h1;
  localparam ST_STROBE = 3'h2;
  localparam ST_WAIT = 3'h3;
  localparam ST_RELEASE = 3'h4;
  localparam ST_HOLD = 3'h5;
  localparam ST_TURN = 3'h6;

  wire extendedWaitEnable;
  wire [31:0] timeReg;
  wire [7:0] maxWaitCycles;
  wire [20:0] wrAddr;
  wire [15:0] wrData;
  wire startPulse;
  wire waitSync;
  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [7:0] cnt_r;
  reg [7:0] cnt_nxt;
  reg [3:0] step_r;
  reg [3:0] step_nxt;
  reg [CNT_W-1:0] waitCount_r;
  reg [CNT_W-1:0] waitCount_nxt;
  reg [CNT_W-1:0] lastWait_r;
  reg timeout_r;
  reg timeout_nxt;
  reg sawWait_r;
  reg sawWait_nxt;

  wire [3:0] writeSetupCycles = timeReg[`AMWS_TIME_SETUP];
  wire [5:0] writeStrobeCycles = timeReg[`AMWS_TIME_STROBE];
  wire [3:0] writeHoldCycles = timeReg[`AMWS_TIME_HOLD];
  wire [1:0] turnaroundCycles = timeReg[`AMWS_TIME_TURN];
  // Last count of a 16-cycle wait step, cut to the step counter width
  wire [4:0] waitStepLast = `AMWS_WAIT_STEP - 5'h1;
  wire busy = (state_r != ST_IDLE);
  // Max wait of zero means full range of 256 wait cycles
  wire [CNT_W-1:0] waitLimit = (maxWaitCycles == 8'h0) ?
    9'h100 : {1'b0, maxWaitCycles};

  // ==========================================================
  // Register file
  amws_wb_regs uRegs (
    .clk_sys(clk_sys),
    .reset(reset),
    .clkEn(clkEn),
    .wbCyc(wbCyc),
    .wbStb(wbStb),
    .wbWe(wbWe),
    .wbSel(wbSel),
    .wbAdr(wbAdr),
    .wbDatIn(wbDatIn),
    .wbDatOut(wbDatOut),
    .wbAck(wbAck),
    .extendedWaitEnable(extendedWaitEnable),
    .timeReg(timeReg),
    .maxWaitCycles(maxWaitCycles),
    .wrAddr(wrAddr),
    .wrData(wrData),
    .startPulse(startPulse),
    .busy(busy),
    .timeoutSticky(timeout_r),
    .lastWaitCount(lastWait_r)
  );

  // ==========================================================
  // Wait input synchroniser
  amws_wait_sync uSync (
    .clk_sys(clk_sys),
    .reset(reset),
    .clkEn(clkEn),
    .asyncIn(ext_wait_input),
    .syncOut(waitSync)
  );

  // ==========================================================
  // Next-state logic; every phase counts clk_sys cycles
  always @* begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    step_nxt = step_r;
    waitCount_nxt = waitCount_r;
    timeout_nxt = timeout_r;
    sawWait_nxt = sawWait_r;
    case (state_r)
      ST_IDLE: begin
        if (startPulse) begin
          state_nxt = ST_SETUP;
          cnt_nxt = {4'h0, writeSetupCycles};
          timeout_nxt = 1'b0;
          waitCount_nxt = {CNT_W{1'b0}};
          sawWait_nxt = 1'b0;
        end
      end
      ST_SETUP: begin
        if (cnt_r <= 8'h1) begin
          state_nxt = ST_STROBE;
          cnt_nxt = {2'h0, writeStrobeCycles};
        end else begin
          cnt_nxt = cnt_r - 8'h1;
        end
      end
      ST_STROBE: begin
        if (extendedWaitEnable && waitSync) begin
          sawWait_nxt = 1'b1;
        end
        if (cnt_r <= 8'h1) begin
          if (extendedWaitEnable && (waitSync || sawWait_r)) begin
            state_nxt = ST_WAIT;
            step_nxt = waitStepLast[3:0];
          end else begin
            state_nxt = ST_HOLD;
            cnt_nxt = {4'h0, writeHoldCycles};
          end
        end else begin
          cnt_nxt = cnt_r - 8'h1;
        end
      end
      ST_WAIT: begin
        // Each 16-cycle step counts one external wait cycle
        if (step_r == 4'h0) begin
          step_nxt = waitStepLast[3:0];
          waitCount_nxt = waitCount_r + 9'h1;
          if (!waitSync) begin
            state_nxt = ST_RELEASE;
            cnt_nxt = {5'h0, `AMWS_RELEASE_DLY} - 8'h1;
          end else if (waitCount_r + 9'h1 >= waitLimit) begin
            state_nxt = ST_HOLD;
            cnt_nxt = {4'h0, writeHoldCycles};
            timeout_nxt = 1'b1;
          end
        end else begin
          step_nxt = step_r - 4'h1;
        end
      end
      ST_RELEASE: begin
        if (cnt_r <= 8'h1) begin
          state_nxt = ST_HOLD;
          cnt_nxt = {4'h0, writeHoldCycles};
        end else begin
          cnt_nxt = cnt_r - 8'h1;
        end
      end
      ST_HOLD: begin
        if (cnt_r <= 8'h1) begin
          state_nxt = ST_TURN;
          cnt_nxt = {6'h0, turnaroundCycles};
        end else begin
          cnt_nxt = cnt_r - 8'h1;
        end
      end
      ST_TURN: begin
        if (cnt_r <= 8'h1) begin
          state_nxt = ST_IDLE;
        end else begin
          cnt_nxt = cnt_r - 8'h1;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // ==========================================================
  // State registers and pin drivers, all from flops
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state_r <= ST_IDLE;
      cnt_r <= 8'h0;
      step_r <= 4'h0;
      waitCount_r <= {CNT_W{1'b0}};
      lastWait_r <= {CNT_W{1'b0}};
      timeout_r <= 1'b0;
      sawWait_r <= 1'b0;
      ext_write_strobe_n <= 1'b1;
      ext_address_bus <= 21'h0;
      extDataOut <= 16'h0;
      extDataOe <= 1'b0;
    end else if (clkEn) begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      step_r <= step_nxt;
      waitCount_r <= waitCount_nxt;
      timeout_r <= timeout_nxt;
      sawWait_r <= sawWait_nxt;
      if (state_r == ST_HOLD && state_nxt == ST_TURN) begin
        lastWait_r <= waitCount_r;
      end
      // Strobe low in strobe, wait and release phases
      ext_write_strobe_n <= ~((state_nxt == ST_STROBE) ||
        (state_nxt == ST_WAIT) || (state_nxt == ST_RELEASE));
      // Address and data held from setup through hold
      if (state_r == ST_IDLE && state_nxt == ST_SETUP) begin
        ext_address_bus <= wrAddr;
        extDataOut <= wrData;
      end
      extDataOe <= (state_nxt != ST_IDLE) && (state_nxt != ST_TURN);
    end
  end
endmodule

// File: amws_monitor.sv
// Port checker for the write strobe sequencer
`timescale 1ns/1ps
module amws_monitor #(
  parameter CNT_W = 9
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Register bus
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [4:0] wbAdr,
  input wire logic [31:0] wbDatIn,
  input wire logic wbAck,
  // Memory pins
  input wire logic ext_write_strobe_n,
  input wire logic [20:0] ext_address_bus,
  input wire logic [15:0] extDataOut,
  input wire logic extDataOe,
  input wire logic ext_wait_input
);
  // ==========================================
  // Helper state and relations
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  logic ewShadow_r;
  logic [12:0] lowCnt_r;
  // Shadow of the wait enable bit and length of the current strobe
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ewShadow_r <= 1'h0;
      lowCnt_r <= 13'h0;
    end else begin
      if (wbAck && wbWe && wbAdr == 5'h00) ewShadow_r <= wbDatIn[0];
      lowCnt_r <= ext_write_strobe_n ? 13'h0 : lowCnt_r + 13'h1;
    end
  end
  sequence sReq;
    wbCyc && wbStb && !wbAck;
  endsequence
  sequence sWaitSeen;
    ext_wait_input [*4];
  endsequence
  // Bus answer, setup, strobe and hold relations
  chk_ack_next: assert property (sReq |=> wbAck)
    else $error("no ack one cycle after request");
  chk_setup_valid: assert property ($fell(ext_write_strobe_n) |->
    $past(extDataOe) && $stable(ext_address_bus) && $stable(extDataOut))
    else $error("address or data not set up before strobe");
  chk_low_steady: assert property (!ext_write_strobe_n &&
    !$past(ext_write_strobe_n) |-> extDataOe && $stable(extDataOut))
    else $error("data moved while strobe low");
  chk_hold_valid: assert property ($rose(ext_write_strobe_n) |->
    extDataOe && $stable(ext_address_bus) && $stable(extDataOut))
    else $error("address or data dropped at strobe end");
  chk_plain_width: assert property (!ewShadow_r &&
    !ext_write_strobe_n |-> lowCnt_r < 13'h40)
    else $error("strobe too long without wait");
  chk_wait_bound: assert property (!ext_write_strobe_n |->
    lowCnt_r < 13'h1080)
    else $error("strobe beyond wait limit");
  chk_wait_seen: assert property (sWaitSeen ##0 (ewShadow_r &&
    !ext_write_strobe_n && lowCnt_r < 13'he) |=> !ext_write_strobe_n)
    else $error("wait did not extend strobe");
  chk_release_gap: assert property (ewShadow_r &&
    !ext_write_strobe_n && $fell(ext_wait_input) |-> ##[1:24]
    ext_write_strobe_n)
    else $error("strobe not released after wait");
endmodule
bind amws_write_seq amws_monitor #(.CNT_W(CNT_W)) mon_u (.clk_sys, .reset,
  .wbCyc, .wbStb, .wbWe, .wbAdr, .wbDatIn, .wbAck, .ext_write_strobe_n,
  .ext_address_bus, .extDataOut, .extDataOe, .ext_wait_input);

// File: amws_mem_model.sv
// Behavioural asynchronous memory at the far side of the strobe
`timescale 1ns/1ps
module amws_mem_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Memory pins
  input wire logic strobeN,
  input wire logic [20:0] addrIn,
  input wire logic [15:0] dataIn,
  input wire logic dataOe,
  output logic waitOut,
  // Bench control and results
  input wire logic [15:0] waitLen,
  output logic done,
  output logic [20:0] gotAddr,
  output logic [15:0] gotData,
  output int setupLen,
  output int lowLen,
  output int holdLen
);
  logic prevN, prevOe;
  logic [15:0] waitCnt;
  // Measure each phase, capture the word and stretch when asked
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      {prevN, prevOe, waitOut, done} <= 4'h8;
      waitCnt <= 16'h0;
    end else begin
      prevN <= strobeN;
      prevOe <= dataOe;
      done <= prevOe && !dataOe;
      if (dataOe && !prevOe) begin
        {setupLen, lowLen, holdLen} <= {32'h1, 64'h0};
      end else if (dataOe && strobeN) begin
        if (lowLen == 0) setupLen <= setupLen + 1;
        else holdLen <= holdLen + 1;
      end else if (!strobeN) lowLen <= lowLen + 1;
      // Bus not driven shows the inverse of the last word
      if (!strobeN) gotAddr <= addrIn;
      if (!strobeN) gotData <= dataOe ? dataIn : ~gotData;
      if (prevN && !strobeN && waitLen != 16'h0) begin
        waitOut <= 1'h1;
        waitCnt <= waitLen;
      end else if (strobeN) waitOut <= 1'h0;
      else if (waitOut) begin
        waitCnt <= waitCnt - 16'h1;
        if (waitCnt == 16'h1) waitOut <= 1'h0;
      end
    end
  end
endmodule

// File: amws_write_seq_tb_top.sv
// Self-checking bench for the write strobe sequencer
`timescale 1ns/1ps
module amws_write_seq_tb_top;
  typedef struct {logic [20:0] a; logic [15:0] d; int s, w, h, t;} amws_exp_t;
  logic clk_sys = 1'h0, reset = 1'h1, wbCyc = 1'h0, wbStb = 1'h0;
  logic wbWe = 1'h0, wbAck, strobeN, dataOe, waitSig, done;
  logic [4:0] wbAdr = 5'h0;
  logic [31:0] wbDatIn = 32'h0, wbDatOut, rdMask;
  logic [20:0] extAddr, gotAddr;
  logic [15:0] extData, gotData, waitLen = 16'h0;
  int setupLen, lowLen, holdLen, v, mismatches = 0, comparisons = 0;
  logic [31:0] rdQ[$], mkQ[$];
  amws_exp_t memQ[$], ex;
  amws_write_seq dut_u (.clk_sys, .reset, .clkEn(1'h1), .wbCyc, .wbStb,
    .wbWe, .wbSel(4'hf), .wbAdr, .wbDatIn, .wbDatOut, .wbAck,
    .ext_write_strobe_n(strobeN), .ext_address_bus(extAddr),
    .extDataOut(extData), .extDataOe(dataOe), .extDataIn(16'h0),
    .ext_wait_input(waitSig));
  amws_mem_model mem_u (.clk_sys, .reset, .strobeN, .addrIn(extAddr),
    .dataIn(extData), .dataOe, .waitOut(waitSig), .waitLen, .done,
    .gotAddr, .gotData, .setupLen, .lowLen, .holdLen);
  // ==========================================
  // Clock, compare and bus tasks
  always #5 clk_sys = ~clk_sys;
  task automatic cmpVal(string n, logic [31:0] e, logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cmpNear(string n, int e, int g, int t);
    comparisons++;
    if (g < e - t || g > e + t) begin
      mismatches++;
      $display("unexpected %s expected %0d seen %0d", n, e, g);
    end
  endtask
  task automatic wb(logic we, logic [4:0] a, logic [31:0] d, e, m);
    @(posedge clk_sys);
    {wbCyc, wbStb, wbWe, wbAdr, wbDatIn} <= {2'h3, we, a, d};
    if (!we) rdQ.push_back(e);
    if (!we) mkQ.push_back(m);
    @(posedge clk_sys);
    while (wbAck !== 1'h1) @(posedge clk_sys);
    {wbCyc, wbStb} <= 2'h0;
    @(posedge clk_sys);
  endtask
  // One memory write with its timing set, then a status read
  task automatic memWrite(int ws, write_strobe_cycles, wh, ew, wl, el, tol, logic to);
    amws_exp_t x;
    x = '{21'($urandom), 16'($urandom), ws ? ws : 1, el, wh ? wh : 1, tol};
    waitLen <= 16'(wl);
    wb(1'h1, 5'h00, 32'(ew), 0, 0);
    wb(1'h1, 5'h04, {8'h1, 4'h0, 4'(wh), 2'h0, 6'(write_strobe_cycles), 4'h0, 4'(ws)}, 0, 0);
    wb(1'h1, 5'h0c, 32'(x.a), 0, 0);
    memQ.push_back(x);
    wb(1'h1, 5'h10, 32'(x.d), 0, 0);
    for (int i = 0; i < 5000 && memQ.size() != 0; i++) @(posedge clk_sys);
    repeat (4) @(posedge clk_sys);
    wb(1'h0, 5'h14, 0, {30'h0, to, 1'h0}, 32'h3);
  endtask
  task automatic complete_run;
    if (mismatches == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Read data against the oldest note
  always @(posedge clk_sys) begin
    if (wbAck === 1'h1 && !wbWe && rdQ.size() != 0) begin
      rdMask = mkQ.pop_front();
      cmpVal("read data", rdQ.pop_front() & rdMask,
        wbDatOut & rdMask);
    end
  end
  // Finished memory writes against the oldest note
  always @(posedge clk_sys) begin
    if (done === 1'h1 && memQ.size() != 0) begin
      ex = memQ.pop_front();
      cmpVal("address", 32'(ex.a), 32'(gotAddr));
      cmpVal("data", 32'(ex.d), 32'(gotData));
      cmpNear("setup", ex.s, setupLen, 1);
      cmpNear("strobe", ex.w, lowLen, ex.t);
      cmpNear("hold", ex.h, holdLen, 1);
    end
  end
  // Watchdog
  initial begin
    repeat (60000) @(posedge clk_sys);
    mismatches++;
    complete_run;
  end
  // Main sequence
  initial begin
    void'($urandom(32'ha2455b1f));
    repeat (8) @(posedge clk_sys);
    reset <= 1'h0;
    wb(1'h0, 5'h04, 0, 32'h03013f0f, 32'hffffffff);
    wb(1'h0, 5'h08, 0, 32'h80, 32'hff);
    wb(1'h0, 5'h18, 0, 0, 32'hffffffff);
    wb(1'h1, 5'h08, 32'h8, 0, 0);
    wb(1'h0, 5'h08, 0, 32'h8, 32'hff);
    memWrite(0, 0, 0, 0, 0, 1, 1, 1'h0);
    memWrite(15, 63, 15, 0, 0, 63, 1, 1'h0);
    for (int i = 0; i < 4; i++) begin
      v = 1 + $urandom % 63;
      memWrite($urandom % 16, v, $urandom % 16, 0, 0, v, 1,
        1'h0);
    end
    memWrite(2, 5, 2, 0, 40, 5, 1, 1'h0);
    memWrite(2, 6, 2, 1, 17, 22, 3, 1'h0);
    memWrite(3, 10, 3, 1, 37, 42, 3, 1'h0);
    wb(1'h1, 5'h08, 32'h2, 0, 0);
    memWrite(2, 4, 3, 1, 65535, 36, 3, 1'h1);
    complete_run;
  end
endmodule
